// *** bench/host_apb_master.sv ***
`timescale 1ns/1ps
module host_apb_master (
  // Clock
  input wire logic        pclk,
  // Request
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [7:0]      paddr,
  output logic [31:0]     pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end
  // Single-axis commands only, each chain kept within its own axis
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    // Answer taken at the very edge that samples ready high
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_apb_master

// *** bench/prequeue_properties.sv ***
`timescale 1ns/1ps
module prequeue_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt and pulses
  input wire logic        irq,
  input wire logic [3:0]  step_pulse
);
  typedef struct packed {
    logic [2:0] mask;
    logic [3:0] flushed;
  } chk_state_type;
  chk_state_type st_r;
  chk_state_type st_nxt;
  logic          acc;
  logic          aligned;
  assign acc = psel && penable && pready && pwrite;
  // Aliased global offsets are left alone, their decoding is not fixed
  assign aligned = paddr[1:0] == 2'b00 && !(paddr[7] && paddr[6:5] != 2'b00);
  function automatic logic bad(input logic [7:0] a);
    return a[7] ? a[6:0] > 7'h04 : a[4:0] > 5'h10;
  endfunction : bad
  // Shadow of the mask and of axes flushed since their last command
  always_comb begin
    st_nxt = st_r;
    if (acc && paddr == 8'h84) begin
      st_nxt.mask = pwdata[2:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (acc && !paddr[7] && paddr[6:5] == 2'(i) && paddr[4:0] == 5'h0C && pwdata[3]) begin
        st_nxt.flushed[i] = 1'b1;
      end else if (acc && !paddr[7] && paddr[6:5] == 2'(i) && paddr[4:0] == 5'h00) begin
        st_nxt.flushed[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{mask: 3'h1, flushed: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready && step_pulse == 4'h0)
    else $error("outputs not idle after reset");
  a_access_ready: assert property (s_setup |=> s_answer)
    else $error("no ready in first access cycle");
  a_ready_single: assert property (s_answer |=> !pready)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (s_setup ##0 (aligned && bad(paddr)) |=> pslverr)
    else $error("unmapped offset without error");
  a_mapped_ok: assert property (s_setup ##0 (aligned && !bad(paddr)) |=> !pslverr)
    else $error("mapped offset answered with error");
  a_mask_block: assert property ((st_r.mask == 3'h0) [*2] |-> !irq)
    else $error("irq with all sources masked");
  a_pulse_single: assert property (step_pulse != 4'h0 |=> (step_pulse & $past(step_pulse)) == 4'h0)
    else $error("step pulse wider than one cycle");
  a_init_stop: assert property ((step_pulse & st_r.flushed & $past(st_r.flushed, 3)) == 4'h0)
    else $error("pulses on a flushed axis");
endmodule : prequeue_properties

bind motion_command_prequeue prequeue_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .step_pulse(step_pulse));

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  step_pulse;
  logic [31:0] q;
  logic        e;
  int          err_count;
  int          tests_run;
  int          pcnt [4];
  int          cyc;
  int          ptime [$];

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  host_apb_master host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  motion_command_prequeue DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .step_pulse(step_pulse));

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge pclk) begin
    cyc++;
    for (int i = 0; i < 4; i++) begin
      pcnt[i] += int'(step_pulse[i] === 1'b1);
    end
    if (step_pulse[0] === 1'b1) begin
      ptime.push_back(cyc);
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] ra(input int ax, input logic [4:0] off);
    return {1'b0, ax[1:0], off};
  endfunction : ra

  // A few idle cycles let the stage transfers land before the next look
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    repeat (3) @(posedge pclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(name, q, exp);
  endtask : rd_chk

  task automatic wait_empty(input int ax);
    int n;
    n = 0;
    rd(ra(ax, 5'h10));
    while (q[3] !== 1'b1 && n < 5000) begin
      rd(ra(ax, 5'h10));
      n++;
    end
    check("drained", {31'h0, q[3]}, 32'h1);
  endtask : wait_empty

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, err_count);
  endtask : end_test

  task automatic finish_test;
    $display("%0d comparisons, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("peak", ra(0, 5'h04), 32'h100);
    rd_chk("ceil", ra(0, 5'h08), 32'h100);
    rd_chk("ctrl", ra(0, 5'h0C), 32'h0);
    rd_chk("stat", ra(0, 5'h10), 32'h8);
    rd_chk("mask", 8'h84, 32'h1);
    rd_chk("unmapped", ra(0, 5'h14), 32'h0);
    check("unmapped_err", {31'h0, e}, 32'h1);
    wr(ra(0, 5'h10), 32'hF);
    rd_chk("stat_ro", ra(0, 5'h10), 32'h8);
    rd(8'h88);
    check("global_err", {31'h0, e}, 32'h1);
    end_test("reset");
    // Boosted ceiling, a slow first move, then moves queued behind it, a keep-speed move overwriting a plain one held in the full entry stage
    wr(ra(0, 5'h04), 32'hFFFF);
    wr(ra(0, 5'h08), 32'hFFFF);
    wr(ra(0, 5'h0C), 32'h3);
    rd_chk("ctrl_set", ra(0, 5'h0C), 32'h3);
    wr(ra(0, 5'h00), 32'h3);
    rd_chk("stat_act", ra(0, 5'h10), 32'h1);
    wr(ra(0, 5'h00), 32'h8000_0000);
    rd_chk("stat_wait", ra(0, 5'h10), 32'h3);
    wr(ra(0, 5'h00), 32'h5);
    rd_chk("stat_full", ra(0, 5'h10), 32'h7);
    wr(ra(0, 5'h00), 32'h8000_0001);
    rd_chk("stat_over", ra(0, 5'h10), 32'h7);
    rd_chk("other_axis", ra(1, 5'h10), 32'h8);
    wait_empty(0);
    check("pulses", 32'(pcnt[0]), 32'h4);
    check("other_pulses", 32'(pcnt[1]), 32'h0);
    check("gap", 32'(ptime[3] - ptime[2] <= ptime[2] - ptime[1]), 32'h1);
    rd(8'h80);
    check("done_stat", q & 32'h1, 32'h1);
    @(negedge pclk);
    check("irq_done", {31'h0, irq}, 32'h1);
    wr(8'h80, 32'hFFFF);
    @(negedge pclk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    end_test("chain");
    wr(ra(1, 5'h0C), 32'h7);
    rd_chk("unfix", ra(1, 5'h0C), 32'h2);
    end_test("override");
    wr(8'h84, 32'h0);
    wr(ra(2, 5'h00), 32'h0);
    wait_empty(2);
    @(negedge pclk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(8'h80, 32'hFFFF);
    wr(8'h84, 32'h4);
    wr(ra(2, 5'h00), 32'h0);
    wait_empty(2);
    rd(8'h80);
    check("preempty", q & 32'h400, 32'h400);
    @(negedge pclk);
    check("irq_pre", {31'h0, irq}, 32'h1);
    end_test("mask");
    wr(ra(3, 5'h00), 32'h64);
    wr(ra(3, 5'h00), 32'h64);
    rd_chk("stat_busy", ra(3, 5'h10), 32'h3);
    wr(ra(3, 5'h0C), 32'h8);
    rd_chk("stat_init", ra(3, 5'h10), 32'h8);
    end_test("init");
    finish_test();
  end
endmodule : tb_top

// *** design/axis_exec.sv ***
`timescale 1ns/1ps
`include "prequeue_defines.svh"
module axis_exec
  import prequeue_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Link to queue and control
  axis_link.exec    lk
);

  exec_state_type s_r;
  exec_state_type s_nxt;
  logic [15:0]    ceil_eff;
  logic [15:0]    step;
  logic [16:0]    vel_sum;
  logic [24:0]    ph_sum;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.pulse = 1'b0;
    s_nxt.done  = 1'b0;
    // Boost raises the ceiling but the target speed stays peak
    ceil_eff = lk.boost ? lk.ceiling : lk.peak;
    // Coarser step for a higher ceiling, so ramps finish sooner
    step     = ceil_eff >> `RES_SHIFT;
    if (step == 16'h0000) begin
      step = 16'h0001;
    end
    vel_sum  = {1'b0, s_r.vel} + {1'b0, step};
    ph_sum   = {1'b0, s_r.phase} + {9'h000, s_r.vel};
    if (lk.start) begin
      s_nxt.remain = lk.act[`CNT_MSB:0];
      s_nxt.busy   = 1'b1;
      // Keeping speed across the boundary carries the velocity over, so the ramp goes on instead of restarting at zero
      if (!lk.act[`KEEP_SPEED_BIT]) begin
        s_nxt.vel = 16'h0000;
      end
    end else if (s_r.busy) begin
      s_nxt.phase = ph_sum[23:0];
      if (s_r.remain == 24'h000000) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else if (ph_sum[24]) begin
        s_nxt.pulse  = 1'b1;
        s_nxt.remain = s_r.remain - 24'h000001;
        if (s_r.remain == 24'h000001) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
      if (lk.tick && s_r.vel != lk.peak) begin
        if (s_r.vel > lk.peak || vel_sum > {1'b0, lk.peak}) begin
          s_nxt.vel = lk.peak;
        end else begin
          s_nxt.vel = vel_sum[15:0];
        end
      end
    end
    if (lk.flush) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.done  = s_r.done;
  assign lk.pulse = s_r.pulse;

endmodule : axis_exec

// *** design/axis_link.sv ***
`timescale 1ns/1ps
interface axis_link;
  logic        cmd_wr;
  logic [31:0] cmd_data;
  logic        flush;
  logic [15:0] peak;
  logic [15:0] ceiling;
  logic        boost;
  logic        tick;
  logic [31:0] act;
  logic        act_v;
  logic        wait_v;
  logic        ent_v;
  logic        start;
  logic        preempty;
  logic        done;
  logic        pulse;

  modport ctl (output cmd_wr, cmd_data, flush, peak, ceiling, boost, tick,
               input act_v, wait_v, ent_v, preempty, done, pulse);
  modport queue (input cmd_wr, cmd_data, flush, done,
                 output act, act_v, wait_v, ent_v, start, preempty);
  modport exec (input flush, peak, ceiling, boost, tick, act, start,
                output done, pulse);
endinterface : axis_link

// *** design/axis_queue.sv ***
`timescale 1ns/1ps
`include "prequeue_defines.svh"
module axis_queue
  import prequeue_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Link to control and executor
  axis_link.queue   lk
);

  queue_state_type s_r;
  queue_state_type s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.start    = 1'b0;
    if (lk.done) begin
      s_nxt.act_v = 1'b0;
    end
    // Transfers settle in this one cycle
    if (!s_nxt.act_v && s_nxt.wait_v) begin
      s_nxt.act    = s_r.waiting;
      s_nxt.act_v  = 1'b1;
      s_nxt.wait_v = 1'b0;
      s_nxt.start  = 1'b1;
    end else if (!s_nxt.act_v && s_nxt.ent_v) begin
      s_nxt.act    = s_r.ent;
      s_nxt.act_v  = 1'b1;
      s_nxt.ent_v  = 1'b0;
      s_nxt.start  = 1'b1;
    end
    if (s_nxt.act_v && !s_nxt.wait_v && s_nxt.ent_v) begin
      s_nxt.waiting = s_r.ent;
      s_nxt.wait_v  = 1'b1;
      s_nxt.ent_v   = 1'b0;
    end
    // Host write lands last so it survives a same-cycle move, and overwrites when full
    if (lk.cmd_wr) begin
      s_nxt.ent   = lk.cmd_data;
      s_nxt.ent_v = 1'b1;
    end
    s_nxt.preempty = (s_r.ent_v && !s_nxt.ent_v) ||
                     (s_r.wait_v && !s_nxt.wait_v);
    if (lk.flush) begin
      s_nxt.ent_v    = 1'b0;
      s_nxt.wait_v   = 1'b0;
      s_nxt.act_v    = 1'b0;
      s_nxt.start    = 1'b0;
      s_nxt.preempty = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.act      = s_r.act;
  assign lk.act_v    = s_r.act_v;
  assign lk.wait_v   = s_r.wait_v;
  assign lk.ent_v    = s_r.ent_v;
  assign lk.start    = s_r.start;
  assign lk.preempty = s_r.preempty;

endmodule : axis_queue

// *** design/motion_command_prequeue.sv ***
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "prequeue_defines.svh"
module motion_command_prequeue
  import prequeue_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt and pulse outputs
  output logic             irq,
  output logic [3:0]       step_pulse
);

  top_state_type s_r;
  top_state_type s_nxt;

  logic       setup;
  logic       access;
  logic       glob;
  logic [1:0] axis;
  logic [4:0] off;
  logic [3:0] cmd_wr;
  logic [3:0] flush;
  logic [3:0] act_v;
  logic [3:0] wait_v;
  logic [3:0] ent_v;
  logic [3:0] preempty;
  logic [3:0] done;
  logic [3:0] pulse;
  logic [15:0] ev;
  logic [15:0] mask_rep;
  logic [31:0] rdata;
  logic        hit;

  axis_link lk[`AXES] ();

  assign setup  = psel && !penable;
  assign access = psel && penable && s_r.pready;
  assign glob   = paddr[`GLOBAL_BIT];
  assign axis   = paddr[`AXIS_MSB:`AXIS_LSB];
  assign off    = paddr[`OFF_MSB:0];

  genvar g;
  generate
    for (g = 0; g < `AXES; g++) begin : gen_axis
      // Only the entry stage is writable by the host
      assign cmd_wr[g] = access && pwrite && !glob && axis == g
                         && off == `OFF_CMD;
      assign flush[g]  = access && pwrite && !glob && axis == g && off == `OFF_CTRL
                         && pwdata[`CTRL_INIT];
      assign lk[g].cmd_wr   = cmd_wr[g];
      assign lk[g].cmd_data = pwdata;
      assign lk[g].flush    = flush[g];
      assign lk[g].peak     = s_r.peak[g];
      assign lk[g].ceiling  = s_r.ceil[g];
      assign lk[g].boost    = s_r.boost[g];
      assign lk[g].tick     = s_r.tick;
      assign act_v[g]       = lk[g].act_v;
      assign wait_v[g]      = lk[g].wait_v;
      assign ent_v[g]       = lk[g].ent_v;
      assign preempty[g]    = lk[g].preempty;
      assign done[g]        = lk[g].done;
      assign pulse[g]       = lk[g].pulse;
      // Separate queue and executor per axis keep chains apart
      axis_queue u_queue (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk[g].queue)
      );
      axis_exec u_exec (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk[g].exec)
      );
      assign ev[g*`INT_NIB +: `INT_NIB]       = {1'b0, preempty[g], 1'b0, done[g]};
      assign mask_rep[g*`INT_NIB +: `INT_NIB] = {1'b0, s_r.int_mask};
    end
  endgenerate

  // Read mux, sampled in the setup cycle
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (glob) begin
      unique case (off)
        `OFF_INT_STAT: rdata = {16'h0000, s_r.int_stat};
        `OFF_INT_MASK: rdata = {29'h0000_0000, s_r.int_mask};
        default:       hit   = 1'b0;
      endcase
    end else begin
      unique case (off)
        `OFF_PEAK: rdata = {16'h0000, s_r.peak[axis]};
        `OFF_CEIL: rdata = {16'h0000, s_r.ceil[axis]};
        `OFF_CTRL: rdata = {30'h0000_0000, s_r.conti[axis], s_r.boost[axis]};
        // Occupancy for polling; bit 3 is motion done with everything empty
        `OFF_STAT: rdata = {28'h0000_000, !(act_v[axis] || wait_v[axis] || ent_v[axis]),
                            ent_v[axis], wait_v[axis], act_v[axis]};
        `OFF_CMD:  rdata = 32'h0000_0000;
        default:   hit   = 1'b0;
      endcase
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.tick   = 1'b0;
    // Zero wait state: ready rises for the first access cycle
    if (setup) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !hit;
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : rdata;
    end
    if (access && pwrite) begin
      if (glob) begin
        unique case (off)
          `OFF_INT_STAT: s_nxt.int_stat = s_r.int_stat & ~pwdata[15:0];
          `OFF_INT_MASK: s_nxt.int_mask = pwdata[2:0];
          default: ;
        endcase
      end else begin
        unique case (off)
          `OFF_PEAK: s_nxt.peak[axis] = pwdata[15:0];
          `OFF_CEIL: s_nxt.ceil[axis] = pwdata[15:0];
          `OFF_CTRL: begin
            s_nxt.conti[axis] = pwdata[`CTRL_CONTI];
            if (pwdata[`CTRL_BOOST]) begin
              s_nxt.boost[axis] = 1'b1;
            end
            // Unfix wins if both bits are written together
            if (pwdata[`CTRL_UNFIX]) begin
              s_nxt.boost[axis] = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    // Events set after the clear so a same-cycle event is never lost
    s_nxt.int_stat = s_nxt.int_stat | ev;
    s_nxt.irq      = |(s_nxt.int_stat & mask_rep);
    if (s_r.div == 8'(`RAMP_CYC - 1)) begin
      s_nxt.div  = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.int_mask <= `INT_MASK_RST;
      s_r.peak     <= {`AXES{`PEAK_RST}};
      s_r.ceil     <= {`AXES{`CEIL_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign irq        = s_r.irq;
  assign step_pulse = pulse;

endmodule : motion_command_prequeue

// *** design/prequeue_defines.svh ***
`ifndef PREQUEUE_DEFINES_SVH
`define PREQUEUE_DEFINES_SVH

// Geometry
`define AXES            4
`define CMD_W           32
`define CNT_W           24
`define VEL_W           16
`define PHASE_W         24
`define KEEP_SPEED_BIT  31
`define CNT_MSB         23

// Byte addresses: paddr[7] picks the global block, paddr[6:5] the axis
`define GLOBAL_BIT      7
`define AXIS_MSB        6
`define AXIS_LSB        5
`define OFF_MSB         4
`define OFF_CMD         5'h00
`define OFF_PEAK        5'h04
`define OFF_CEIL        5'h08
`define OFF_CTRL        5'h0C
`define OFF_STAT        5'h10
`define OFF_INT_STAT    5'h00
`define OFF_INT_MASK    5'h04

// Control register bits
`define CTRL_BOOST      0
`define CTRL_CONTI      1
`define CTRL_UNFIX      2
`define CTRL_INIT       3

// Interrupt factor bits, per axis nibble
`define INT_DONE        0
`define INT_PREEMPTY    2
`define INT_NIB         4
`define INT_MASK_RST    3'h1

// Reset values
`define PEAK_RST        16'h0100
`define CEIL_RST        16'h0100

// Velocity step is the ceiling with boost, else the peak, divided by 2**RES_SHIFT
`define RES_SHIFT       8

// Ramp update period
`define CLK_NS          25
`define RAMP_NS         1000
`define RAMP_CYC        (`RAMP_NS / `CLK_NS)
`define DIV_W           8

`endif

// *** design/prequeue_pkg.sv ***
package prequeue_pkg;

  typedef struct packed {
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic                          irq;
    logic [15:0]                   int_stat;
    logic [2:0]                    int_mask;
    logic [3:0][15:0]              peak;
    logic [3:0][15:0]              ceil;
    logic [3:0]                    boost;
    logic [3:0]                    conti;
    logic [7:0]                    div;
    logic                          tick;
  } top_state_type;

  typedef struct packed {
    logic        ent_v;
    logic        wait_v;
    logic        act_v;
    logic [31:0] ent;
    logic [31:0] waiting;
    logic [31:0] act;
    logic        start;
    logic        preempty;
  } queue_state_type;

  typedef struct packed {
    logic [15:0] vel;
    logic [23:0] phase;
    logic [23:0] remain;
    logic        busy;
    logic        pulse;
    logic        done;
  } exec_state_type;

endpackage : prequeue_pkg
